/* hdl/acr_pkg.sv */
// Constants, field layouts and carrier types of the converter configuration register.
package acr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned GLITCH_NS     = 50;
  localparam int unsigned GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] PTR_CONFIG = 4'h2;
  localparam logic [7:0] PTR_RESET  = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h08;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  localparam int unsigned BIT_UNUSED    = 7;
  localparam int unsigned BIT_REF_SEL   = 6;
  localparam int unsigned BIT_SEL2      = 5;
  localparam int unsigned BIT_SEL1      = 4;
  localparam int unsigned BIT_FILTER    = 3;
  localparam int unsigned BIT_ALARM_EN  = 2;
  localparam int unsigned BIT_PIN_FN    = 1;
  localparam int unsigned BIT_POLARITY  = 0;

  localparam logic [1:0] PIN_FN_CLEARED = 2'b10;

  typedef enum logic [1:0] {
    PIN_NONE  = 2'b00,
    PIN_BUSY  = 2'b01,
    PIN_ALARM = 2'b10,
    PIN_CLEAR = 2'b11
  } acr_pin_fn_type;

  typedef enum logic [1:0] {
    WR_IDLE    = 2'b00,
    WR_POINTER = 2'b01,
    WR_DATA    = 2'b10,
    WR_DONE    = 2'b11
  } acr_wr_state_type;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       valid;
    logic [7:0] data;
  } acr_wr_port_type;

  typedef struct packed {
    logic convert_enable;
    logic ref_from_pin;
    logic second_pin_is_input;
    logic channel_two;
  } acr_conv_ctrl_type;

endpackage

/* hdl/acr_line_filter.sv */
// Glitch filter for the two serial lines, with a bypass.
`timescale 1ns/1ps
module acr_line_filter #(
  parameter int unsigned LINES  = 2,
  parameter int unsigned CYCLES = acr_pkg::GLITCH_CYCLES
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             enable,
  input  wire logic [LINES-1:0] line_raw,
  output logic      [LINES-1:0] line_filt
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      logic [CW-1:0] cnt_q;

      // With the filter enabled, a change passes only after it has held for CYCLES clocks; idle lines rest high.
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          cnt_q        <= '0;
          line_filt[g] <= 1'b1;
        end else if (!enable || line_raw[g] == line_filt[g]) begin
          cnt_q        <= '0;
          line_filt[g] <= line_raw[g];
        end else if (cnt_q == CW'(CYCLES - 1)) begin
          cnt_q        <= '0;
          line_filt[g] <= line_raw[g];
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
    end
  endgenerate

endmodule

/* hdl/acr_config_reg.sv */
// Configuration register with pointer routing, channel sequencing and shared pin control.
`timescale 1ns/1ps
module acr_config_reg (
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  input  wire acr_pkg::acr_wr_port_type   wr,
  input  wire logic                       rd_strobe,
  output logic [7:0]                      rd_data,
  output logic [7:0]                      pointer,
  input  wire logic                       scl_raw,
  input  wire logic                       sda_raw,
  output logic                            scl_filt,
  output logic                            sda_filt,
  input  wire logic                       conv_done,
  output acr_pkg::acr_conv_ctrl_type      conv_ctrl,
  input  wire logic                       alert_active,
  input  wire logic                       busy_active,
  output logic                            alert_hw_enable,
  output logic                            alert_clear,
  output logic                            pin_out,
  output logic                            pin_oe_n
);

  acr_pkg::acr_wr_state_type wr_state_q;
  logic [7:0]                cfg_q;
  logic [7:0]                pointer_q;
  logic [7:0]                rd_data_q;
  logic                      seq_ch_q;
  logic                      alert_clear_q;
  logic                      alert_hw_enable_q;
  logic                      pin_out_q;
  logic                      pin_oe_n_q;
  acr_pkg::acr_conv_ctrl_type conv_ctrl_q;
  logic                      cfg_write;
  logic                      seq_mode;
  acr_pkg::acr_pin_fn_type   pin_fn;
  logic                      pin_active;

  // A byte counts only when it is valid, carries no start or stop, falls in the data phase and the pointer's low four bits are 2.
  assign cfg_write = wr.valid && !wr.start && !wr.stop && wr_state_q == acr_pkg::WR_DATA &&
                     pointer_q[3:0] == acr_pkg::PTR_CONFIG;
  assign seq_mode  = cfg_q[acr_pkg::BIT_SEL2] && cfg_q[acr_pkg::BIT_SEL1] &&
                     !cfg_q[acr_pkg::BIT_REF_SEL];
  assign pin_fn    = acr_pkg::acr_pin_fn_type'({cfg_q[acr_pkg::BIT_ALARM_EN],
                                                cfg_q[acr_pkg::BIT_PIN_FN]});

  // Transaction tracking: the first byte of a write is always the pointer.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_state_q <= acr_pkg::WR_IDLE;
    end else if (wr.start) begin
      wr_state_q <= acr_pkg::WR_POINTER;
    end else if (wr.stop) begin
      wr_state_q <= acr_pkg::WR_IDLE;
    end else if (wr.valid) begin
      case (wr_state_q)
        acr_pkg::WR_POINTER: wr_state_q <= acr_pkg::WR_DATA;
        acr_pkg::WR_DATA:    wr_state_q <= acr_pkg::WR_DONE;
        acr_pkg::WR_DONE:    wr_state_q <= acr_pkg::WR_DONE;
        default:             wr_state_q <= acr_pkg::WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pointer_q <= acr_pkg::PTR_RESET;
    end else if (wr.valid && !wr.start && !wr.stop && wr_state_q == acr_pkg::WR_POINTER) begin
      pointer_q <= wr.data;
    end
  end

  // Configuration store; the top bit is kept only so that it reads back.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= acr_pkg::CFG_RESET;
    end else if (cfg_write) begin
      cfg_q <= wr.data;
      if (wr.data[acr_pkg::BIT_ALARM_EN:acr_pkg::BIT_PIN_FN] == acr_pkg::PIN_CLEAR) begin
        cfg_q[acr_pkg::BIT_ALARM_EN:acr_pkg::BIT_PIN_FN] <= acr_pkg::PIN_FN_CLEARED;
      end
    end
  end

  // The clear is a one-cycle pulse to the limit logic, which owns the flags it resets.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_clear_q <= 1'b0;
    end else begin
      alert_clear_q <= cfg_write &&
                       wr.data[acr_pkg::BIT_ALARM_EN:acr_pkg::BIT_PIN_FN] == acr_pkg::PIN_CLEAR;
    end
  end

  // A new setting restarts the sequence on input one; a write beats a finishing conversion.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seq_ch_q <= 1'b0;
    end else if (cfg_write) begin
      seq_ch_q <= 1'b0;
    end else if (conv_done && seq_mode) begin
      seq_ch_q <= !seq_ch_q;
    end
  end

  // Conversion steering; selecting input two overrides the reference selection.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      conv_ctrl_q <= '0;
    end else begin
      conv_ctrl_q.convert_enable      <= cfg_q[acr_pkg::BIT_SEL2] ||
                                         cfg_q[acr_pkg::BIT_SEL1];
      conv_ctrl_q.ref_from_pin        <= cfg_q[acr_pkg::BIT_REF_SEL] &&
                                         !cfg_q[acr_pkg::BIT_SEL2];
      conv_ctrl_q.second_pin_is_input <= !cfg_q[acr_pkg::BIT_REF_SEL] ||
                                         cfg_q[acr_pkg::BIT_SEL2];
      conv_ctrl_q.channel_two         <= seq_mode ? seq_ch_q :
                                         (cfg_q[acr_pkg::BIT_SEL2] &&
                                          !cfg_q[acr_pkg::BIT_SEL1]);
    end
  end

  always_comb begin
    case (pin_fn)
      acr_pkg::PIN_ALARM: pin_active = alert_active;
      acr_pkg::PIN_BUSY:  pin_active = busy_active;
      default:            pin_active = 1'b0;
    endcase
  end

  // With no function selected the pin is released and sits at its inactive level.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_out_q         <= 1'b1;
      pin_oe_n_q        <= 1'b1;
      alert_hw_enable_q <= 1'b0;
    end else begin
      pin_out_q         <= cfg_q[acr_pkg::BIT_POLARITY] ? pin_active : !pin_active;
      pin_oe_n_q        <= pin_fn == acr_pkg::PIN_NONE;
      alert_hw_enable_q <= cfg_q[acr_pkg::BIT_ALARM_EN];
    end
  end

  // Only the configuration register lives here; pointers whose low four bits are not 2 read as zero.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= acr_pkg::RD_UNMAPPED;
    end else if (rd_strobe) begin
      rd_data_q <= (pointer_q[3:0] == acr_pkg::PTR_CONFIG) ? cfg_q :
                   acr_pkg::RD_UNMAPPED;
    end
  end

  acr_line_filter #(
    .LINES  (2),
    .CYCLES (acr_pkg::GLITCH_CYCLES)
  ) u_filter (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .enable    (cfg_q[acr_pkg::BIT_FILTER]),
    .line_raw  ({scl_raw, sda_raw}),
    .line_filt ({scl_filt, sda_filt})
  );

  assign rd_data         = rd_data_q;
  assign pointer         = pointer_q;
  assign conv_ctrl       = conv_ctrl_q;
  assign alert_hw_enable = alert_hw_enable_q;
  assign alert_clear     = alert_clear_q;
  assign pin_out         = pin_out_q;
  assign pin_oe_n        = pin_oe_n_q;

  sequence s_cfg_write_plain;
    cfg_write && wr.data[2:1] != 2'b11;
  endsequence

  sequence s_cfg_write_clear;
    cfg_write && wr.data[2:1] == 2'b11;
  endsequence

  a_cfg_takes_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_cfg_write_plain |=> cfg_q == $past(wr.data))
    else $error("Configuration byte not stored.");

  a_clear_reads_10: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_cfg_write_clear |=> cfg_q[2:1] == 2'b10 && alert_clear_q ##1 !alert_clear_q)
    else $error("Alarm clear write handled wrongly.");

  a_single_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_state_q == acr_pkg::WR_DONE && wr.valid && !wr.start |=> $stable(cfg_q))
    else $error("Extra data byte changed the configuration.");

  a_pointer_route: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_state_q == acr_pkg::WR_DATA && wr.valid && pointer_q[3:0] != 4'h2 |=> $stable(cfg_q))
    else $error("Byte for another register reached the configuration.");

  a_seq_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_write && wr.data[6:4] == 3'b011 ##1 !conv_done |=> !conv_ctrl_q.channel_two)
    else $error("Sequence did not restart on input one.");

  a_seq_alternate: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_done && seq_mode && !cfg_write |=> seq_ch_q != $past(seq_ch_q))
    else $error("Sequence failed to alternate.");

  a_no_convert: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_q[5:4] == 2'b00 && !cfg_write |=> ##1 !conv_ctrl_q.convert_enable)
    else $error("Conversion enabled with no input selected.");

  a_second_forces_supply: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_q[5] |=> !conv_ctrl_q.ref_from_pin && conv_ctrl_q.second_pin_is_input)
    else $error("Second input selected but reference taken from pin.");

  a_idle_pin_level: assert property (@(posedge sys_clk) disable iff (!rstn)
    pin_fn == acr_pkg::PIN_NONE |=> pin_oe_n_q && pin_out_q == !$past(cfg_q[0]))
    else $error("Idle pin level does not follow polarity.");

  a_busy_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
    pin_fn == acr_pkg::PIN_BUSY |=> !pin_oe_n_q && pin_out_q == ($past(busy_active) ~^ $past(cfg_q[0])))
    else $error("Busy function not driven on the pin.");

  a_filter_bypass: assert property (@(posedge sys_clk) disable iff (!rstn)
    !cfg_q[3] |=> scl_filt == $past(scl_raw) && sda_filt == $past(sda_raw))
    else $error("Serial lines not bypassed with filter off.");

  a_reset_config: assert property (@(posedge sys_clk)
    $rose(rstn) |-> cfg_q == acr_pkg::CFG_RESET && pointer_q == acr_pkg::PTR_RESET)
    else $error("Configuration or pointer not at reset value after reset.");

  a_pin_reference: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_q[6] && !cfg_q[5] |=> conv_ctrl_q.ref_from_pin && !conv_ctrl_q.second_pin_is_input)
    else $error("Selection bit set but shared pin not used as reference.");

  a_first_supply_ref: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_q[6:4] == 3'b001 |=> conv_ctrl_q.convert_enable && !conv_ctrl_q.ref_from_pin &&
                             !conv_ctrl_q.channel_two)
    else $error("Input one alone did not use the supply reference.");

  a_second_pin_input: assert property (@(posedge sys_clk) disable iff (!rstn)
    !cfg_q[6] |=> conv_ctrl_q.second_pin_is_input && !conv_ctrl_q.ref_from_pin)
    else $error("Selection bit clear but shared pin not an input.");

  a_convert_selected: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_q[5] || cfg_q[4] |=> conv_ctrl_q.convert_enable)
    else $error("Selected input not converted.");

  a_second_alone: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_q[5:4] == 2'b10 |=> conv_ctrl_q.channel_two)
    else $error("Input two alone not converted.");

  a_seq_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_mode && !conv_done && !cfg_write |=> $stable(seq_ch_q))
    else $error("Sequence moved with no conversion finished.");

  a_seq_steers: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_mode |=> conv_ctrl_q.channel_two == $past(seq_ch_q))
    else $error("Sequence input not steered to the converter.");

  a_alarm_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> alert_hw_enable_q == $past(cfg_q[2]))
    else $error("Hardware alarm enable does not follow its bit.");

  a_alarm_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
    pin_fn == acr_pkg::PIN_ALARM |=>
      !pin_oe_n_q && pin_out_q == ($past(alert_active) ~^ $past(cfg_q[0])))
    else $error("Alarm function not driven on the pin.");

  a_clear_from_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    alert_clear_q |-> $past(cfg_write) && $past(wr.data[2:1]) == 2'b11)
    else $error("Alarm clear pulsed without a clearing write.");

  a_pointer_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_state_q == acr_pkg::WR_POINTER && wr.valid && !wr.start && !wr.stop |=>
      pointer_q == $past(wr.data))
    else $error("Pointer byte not stored.");

  a_read_config: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_strobe && pointer_q[3:0] == acr_pkg::PTR_CONFIG |=> rd_data_q == $past(cfg_q))
    else $error("Configuration read returned the wrong byte.");

  a_read_other: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_strobe && pointer_q[3:0] != acr_pkg::PTR_CONFIG |=> rd_data_q == acr_pkg::RD_UNMAPPED)
    else $error("Read of another register did not return zero.");

  a_read_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
    !rd_strobe |=> $stable(rd_data_q))
    else $error("Read data changed without a read strobe.");

  // A filtered edge may only pass after the raw line has held its new level.
  a_filter_settle: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(cfg_q[3]) && $past(cfg_q[3], 2) && scl_filt != $past(scl_filt) |->
      $past(scl_raw, 2) == scl_filt)
    else $error("Filtered clock line changed before the raw line settled.");

endmodule

/* tb/acr_host_model.sv */
// Byte-level host model that writes and reads the configuration register.
`timescale 1ns/1ps
module acr_host_model (
  input  wire logic                 sys_clk,
  output acr_pkg::acr_wr_port_type  wr,
  output logic                      rd_strobe,
  input  wire logic [7:0]           rd_data
);
  initial begin
    wr = '0;
    rd_strobe = 1'b0;
  end

  // Idle data toggles on every idle beat that send drives, so a stale byte can never be mistaken for a real one.
  task automatic send(input logic s, input logic p, input logic v, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    wr.start = s;
    wr.stop = p;
    wr.valid = v;
    wr.data = v ? d : ~wr.data;
  endtask

  // One start, the pointer byte, n data bytes and a stop; n is one for a plain write and zero when read_reg only sets the pointer.
  task automatic write_txn(input logic [7:0] ptr, input logic [7:0] dat, input int n);
    send(1'b1, 1'b0, 1'b0, 8'h00);
    send(1'b0, 1'b0, 1'b1, ptr);
    for (int i = 0; i < n; i++) begin
      send(1'b0, 1'b0, 1'b1, (i == 0) ? dat : ~dat);
    end
    send(1'b0, 1'b1, 1'b0, 8'h00);
    send(1'b0, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] val);
    write_txn(ptr, 8'h00, 0);
    @(posedge sys_clk);
    #1;
    rd_strobe = 1'b1;
    @(posedge sys_clk);
    #1;
    rd_strobe = 1'b0;
    val = rd_data;
  endtask
endmodule

/* tb/adc_config_register_tb_top.sv */
// Self-checking testbench of the converter configuration register.
`timescale 1ns/1ps
module adc_config_register_tb_top;
  logic                       sys_clk, rstn, rd_strobe, scl_raw, sda_raw, scl_filt, sda_filt;
  logic                       conv_done, alert_active, busy_active, alert_hw_enable;
  logic                       alert_clear, pin_out, pin_oe_n;
  logic [7:0]                 rd_data, pointer, v;
  acr_pkg::acr_wr_port_type   wr;
  acr_pkg::acr_conv_ctrl_type conv_ctrl;
  int                         fails, check_count, clr_seen, c0;
  logic [7:0]                 cfg_tab [7] = '{8'h08, 8'h80, 8'h10, 8'h50, 8'h20, 8'h00, 8'h14};
  logic [3:0]                 ctl_tab [7] = '{4'h2, 4'h2, 4'ha, 4'hc, 4'hb, 4'h2, 4'ha};
  logic [11:0]                pin_tab [7] = '{12'h059, 12'h050, 12'h048, 12'h035, 12'h024,
                                              12'h021, 12'h01e};

  acr_config_reg dut (.sys_clk(sys_clk), .rstn(rstn), .wr(wr), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .pointer(pointer), .scl_raw(scl_raw), .sda_raw(sda_raw),
    .scl_filt(scl_filt), .sda_filt(sda_filt), .conv_done(conv_done), .conv_ctrl(conv_ctrl),
    .alert_active(alert_active), .busy_active(busy_active),
    .alert_hw_enable(alert_hw_enable), .alert_clear(alert_clear), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  acr_host_model host (.sys_clk(sys_clk), .wr(wr), .rd_strobe(rd_strobe), .rd_data(rd_data));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (alert_clear === 1'b1) begin
      clr_seen++;
    end
  end

  task automatic check8(input string name, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic cfg_write(input logic [7:0] d);
    host.write_txn(8'h02, d, 1);
    cycles(2);
  endtask

  task automatic pulse_done(input logic [3:0] e);
    conv_done = 1'b1;
    cycles(1);
    conv_done = 1'b0;
    cycles(2);
    check8("conv_ctrl", {4'h0, e}, {4'h0, conv_ctrl});
  endtask

  // Both lines dip low for n cycles; the filtered copies are looked at before they rise again.
  task automatic glitch(input int n, input logic e);
    scl_raw = 1'b0;
    sda_raw = 1'b0;
    cycles(n);
    check8("scl_filt", {7'h0, e}, {7'h0, scl_filt});
    check8("sda_filt", {7'h0, e}, {7'h0, sda_filt});
    scl_raw = 1'b1;
    sda_raw = 1'b1;
    cycles(8);
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    stop_test();
  end

  initial begin
    {sys_clk, rstn, conv_done, alert_active, busy_active} = 5'b00000;
    {scl_raw, sda_raw, fails, check_count, clr_seen} = '1;
    {fails, check_count, clr_seen} = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    cycles(2);
    check8("pin_oe_n", 8'h01, {7'h0, pin_oe_n});
    check8("pin_out", 8'h01, {7'h0, pin_out});
    host.read_reg(8'h00, v);
    check8("unmapped", 8'h00, v);
    host.read_reg(8'h02, v);
    check8("cfg reset", acr_pkg::CFG_RESET, v);
    glitch(2, 1'b1);
    glitch(8, 1'b0);
    for (int i = 0; i < 7; i++) begin
      cfg_write(cfg_tab[i]);
      host.read_reg(8'h02, v);
      check8("cfg readback", cfg_tab[i], v);
      check8("conv_ctrl", {4'h0, ctl_tab[i]}, {4'h0, conv_ctrl});
      check8("alert_hw_enable", {7'h0, cfg_tab[i][2]}, {7'h0, alert_hw_enable});
    end
    cfg_write(8'h00);
    glitch(2, 1'b0);
    for (int i = 0; i < 7; i++) begin
      {alert_active, busy_active} = pin_tab[i][3:2];
      cfg_write(pin_tab[i][11:4]);
      cycles(1);
      check8("pin_oe_n", {7'h0, pin_tab[i][1]}, {7'h0, pin_oe_n});
      check8("pin_out", {7'h0, pin_tab[i][0]}, {7'h0, pin_out});
      check8("alert_hw_enable", {7'h0, pin_tab[i][6]}, {7'h0, alert_hw_enable});
    end
    c0 = clr_seen;
    cfg_write(8'h07);
    cycles(2);
    check8("alert_clear pulses", 8'h01, 8'(clr_seen - c0));
    host.read_reg(8'h02, v);
    check8("cfg after clear", 8'h05, v);
    host.write_txn(8'h03, 8'hff, 1);
    check8("pointer", 8'h03, pointer);
    host.read_reg(8'h02, v);
    check8("cfg other pointer", 8'h05, v);
    host.write_txn(8'h02, 8'h10, 2);
    host.read_reg(8'h02, v);
    check8("cfg extra byte", 8'h10, v);
    cfg_write(8'h30);
    check8("conv_ctrl", 8'h0a, {4'h0, conv_ctrl});
    pulse_done(4'hb);
    pulse_done(4'ha);
    pulse_done(4'hb);
    cfg_write(8'h30);
    check8("conv_ctrl", 8'h0a, {4'h0, conv_ctrl});
    // A reset in mid-run must bring back the power-up settings.
    rstn = 1'b0;
    cycles(3);
    rstn = 1'b1;
    cycles(2);
    check8("pointer reset", acr_pkg::PTR_RESET, pointer);
    check8("conv_ctrl reset", 8'h02, {4'h0, conv_ctrl});
    check8("pin_oe_n reset", 8'h01, {7'h0, pin_oe_n});
    host.read_reg(8'h02, v);
    check8("cfg reset again", acr_pkg::CFG_RESET, v);
    stop_test();
  end
endmodule
